/* hdl/nvcd_pkg.sv */
// Constants and carrier types for the nonvolatile memory timing clock divider
package nvcd_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] RATIO_OFFSET   = 12'h000;
    localparam logic [ADDR_W-1:0] OPTION_OFFSET  = 12'h004;
    localparam logic [ADDR_W-1:0] COMMAND_OFFSET = 12'h008;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET  = 12'h00C;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int LOADED_BIT     = 7;
    localparam int PRESCALE_BIT   = 6;
    localparam int DIVISOR_LSB    = 0;
    localparam int DIVISOR_W      = 6;
    localparam int CMD_KIND_LSB   = 0;
    localparam int CMD_TARGET_BIT = 2;
    localparam int CMD_COUNT_LSB  = 8;
    localparam int CMD_COUNT_W    = 8;
    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_DONE_BIT    = 1;
    localparam int ST_REFUSED_BIT = 2;
    localparam int ST_RANGE_BIT   = 3;
    localparam int ST_OPTION_BIT  = 4;
    localparam int ST_REMAIN_LSB  = 8;
    localparam logic [7:0] RATIO_RESET  = 8'h00;
    localparam logic [7:0] OPTION_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Clocking and timing window of the divided clock
    // ------------------------------------------------------------------
    localparam int PRESCALE_DIV   = 8;
    localparam int PRE_CNT_W      = 3;
    localparam int PERIOD_W       = 10;
    localparam int CLK_PERIOD_NS  = 20;
    localparam int CLK_KHZ        = 1000000 / CLK_PERIOD_NS;
    localparam int TIMING_MAX_KHZ = 200;
    localparam int TIMING_MIN_KHZ = 150;
    localparam int MIN_PERIOD_CYC = (CLK_KHZ + TIMING_MAX_KHZ - 1) / TIMING_MAX_KHZ;
    localparam int MAX_PERIOD_CYC = CLK_KHZ / TIMING_MIN_KHZ;

    // ------------------------------------------------------------------
    // Enumerations and carriers
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_NONE    = 2'b00,
        OP_PROGRAM = 2'b01,
        OP_ERASE   = 2'b10,
        OP_ILLEGAL = 2'b11
    } nvcd_op_type;

    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'b00,
        SEQ_ALIGN = 2'b01,
        SEQ_PULSE = 2'b10
    } nvcd_seq_type;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } nvcd_apb_req_type;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } nvcd_apb_rsp_type;

    typedef struct packed {
        logic                 loaded;
        logic                 prescale_by_eight;
        logic [DIVISOR_W-1:0] divisor;
    } nvcd_ratio_type;

    typedef struct packed {
        logic        active;
        logic        pulse_start;
        nvcd_op_type kind;
        logic        target_eeprom;
    } nvcd_nv_ctrl_type;

endpackage

/* hdl/nvcd_clock_divider.sv */
// Timing clock divider, write-once ratio register and pulse sequencer for the nonvolatile arrays

// Behaviour
// RULE1 - First ratio write after reset sets loaded flag
// RULE2 - Reset clears loaded flag; software cannot
// RULE3 - Program and erase refused until flag set
// RULE4 - Prescale bit selects bus clock or divide-by-eight
// RULE5 - Prescale and divisor accept only one write
// RULE6 - Timing clock is input over divisor plus one
// RULE7 - Software keeps timing clock within 150-200 kHz
// RULE8 - Each timing pulse lasts one divided period
// RULE9 - Operations last a whole number of pulses
// RULE10 - Option location copied to shadow during reset; code copies it on the first clock after reset ends
// RULE11 - Option change needs reprogram and new reset
// RULE12 - Later ratio writes ignored, captured values read
module nvcd_clock_divider
(
    input  wire logic                       ref_clk,
    input  wire logic                       rst,
    input  wire nvcd_pkg::nvcd_apb_req_type apb_req,
    output      nvcd_pkg::nvcd_apb_rsp_type apb_rsp,
    input  wire logic [7:0]                 option_nonvolatile_location,
    output      logic [7:0]                 option_shadow_reg,
    output      logic                       ratio_loaded_flag,
    output      logic                       nv_timing_clock,
    output      nvcd_pkg::nvcd_nv_ctrl_type nv_ctrl
);

    // ------------------------------------------------------------------
    // State of the block
    // ------------------------------------------------------------------
    typedef struct packed {
        nvcd_pkg::nvcd_apb_rsp_type               rsp;
        nvcd_pkg::nvcd_ratio_type                 ratio;
        logic [7:0]                               option;
        logic                                     option_valid;
        logic [nvcd_pkg::PRE_CNT_W-1:0]           pre_cnt;
        logic [nvcd_pkg::DIVISOR_W-1:0]           div_cnt;
        logic                                     tick;
        nvcd_pkg::nvcd_seq_type                   seq;
        logic [nvcd_pkg::CMD_COUNT_W-1:0]         remain;
        logic                                     done;
        logic                                     refused;
        logic                                     range_ok;
        nvcd_pkg::nvcd_nv_ctrl_type               nv;
    } nvcd_state_type;

    nvcd_state_type s_q;
    nvcd_state_type s_d;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // True for the four word addresses the block answers
    function automatic logic is_mapped(input logic [nvcd_pkg::ADDR_W-1:0] addr);
        is_mapped = (addr == nvcd_pkg::RATIO_OFFSET)   ||
                    (addr == nvcd_pkg::OPTION_OFFSET)  ||
                    (addr == nvcd_pkg::COMMAND_OFFSET) ||
                    (addr == nvcd_pkg::STATUS_OFFSET);
    endfunction

    // Bus clocks in one divided period for a ratio setting
    function automatic logic [nvcd_pkg::PERIOD_W-1:0] period_cycles(input nvcd_pkg::nvcd_ratio_type r);
        logic [nvcd_pkg::PERIOD_W-1:0] base;
        base = nvcd_pkg::PERIOD_W'(r.divisor) + nvcd_pkg::PERIOD_W'(1);
        if (r.prescale_by_eight)
        begin
            period_cycles = nvcd_pkg::PERIOD_W'(base * nvcd_pkg::PERIOD_W'(nvcd_pkg::PRESCALE_DIV));
        end
        else
        begin
            period_cycles = base;
        end
    endfunction

    // Read data for a mapped word, zero elsewhere
    function automatic logic [nvcd_pkg::DATA_W-1:0] read_word(input logic [nvcd_pkg::ADDR_W-1:0] addr,
                                                              input nvcd_state_type             s);
        logic [nvcd_pkg::DATA_W-1:0] w;
        w = '0;
        unique case (addr)
            nvcd_pkg::RATIO_OFFSET:
            begin
                w[nvcd_pkg::LOADED_BIT]   = s.ratio.loaded;
                w[nvcd_pkg::PRESCALE_BIT] = s.ratio.prescale_by_eight;
                w[nvcd_pkg::DIVISOR_LSB +: nvcd_pkg::DIVISOR_W] = s.ratio.divisor; // RULE12
            end
            nvcd_pkg::OPTION_OFFSET:
            begin
                w[7:0] = s.option;
            end
            nvcd_pkg::COMMAND_OFFSET:
            begin
                w[nvcd_pkg::CMD_KIND_LSB +: 2]  = s.nv.kind;
                w[nvcd_pkg::CMD_TARGET_BIT]     = s.nv.target_eeprom;
            end
            nvcd_pkg::STATUS_OFFSET:
            begin
                w[nvcd_pkg::ST_BUSY_BIT]    = (s.seq != nvcd_pkg::SEQ_IDLE);
                w[nvcd_pkg::ST_DONE_BIT]    = s.done;
                w[nvcd_pkg::ST_REFUSED_BIT] = s.refused;
                w[nvcd_pkg::ST_RANGE_BIT]   = s.range_ok;
                w[nvcd_pkg::ST_OPTION_BIT]  = s.option_valid;
                w[nvcd_pkg::ST_REMAIN_LSB +: nvcd_pkg::CMD_COUNT_W] = s.remain;
            end
            default:
            begin
                w = '0;
            end
        endcase
        read_word = w;
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------

    // Bus decode, register effects, divider and sequencer in one pass
    always_comb
    begin
        logic                              setup;
        logic                              access;
        logic                              wr;
        logic                              pre_tick;
        nvcd_pkg::nvcd_op_type             kind;
        logic [nvcd_pkg::CMD_COUNT_W-1:0]  count;
        logic [nvcd_pkg::PERIOD_W-1:0]     period;
        setup    = 1'b0;
        access   = 1'b0;
        wr       = 1'b0;
        pre_tick = 1'b0;
        kind     = nvcd_pkg::OP_NONE;
        count    = '0;
        period   = '0;
        s_d      = s_q;

        // Zero-wait APB slave: answer registered in the setup cycle, driven in the access cycle
        setup            = apb_req.psel && !apb_req.penable;
        access           = apb_req.psel && apb_req.penable && s_q.rsp.pready;
        wr               = access && apb_req.pwrite && is_mapped(apb_req.paddr);
        s_d.rsp.pready   = setup;
        s_d.rsp.pslverr  = setup && !is_mapped(apb_req.paddr);
        s_d.rsp.prdata   = '0;
        if (setup && !apb_req.pwrite)
        begin
            s_d.rsp.prdata = read_word(apb_req.paddr, s_q);
        end

        // Shadow copy of the option location, caught once after reset
        if (!s_q.option_valid)
        begin
            s_d.option       = option_nonvolatile_location; // RULE10
            s_d.option_valid = 1'b1;
        end

        // Ratio register: only the first write after reset lands
        if (wr && apb_req.paddr == nvcd_pkg::RATIO_OFFSET && !s_q.ratio.loaded) // RULE5 RULE12
        begin
            s_d.ratio.loaded            = 1'b1; // RULE1 RULE2
            s_d.ratio.prescale_by_eight = apb_req.pwdata[nvcd_pkg::PRESCALE_BIT];
            s_d.ratio.divisor           = apb_req.pwdata[nvcd_pkg::DIVISOR_LSB +: nvcd_pkg::DIVISOR_W];
        end

        // Window check on the divided clock for software to read
        period       = period_cycles(s_q.ratio);
        s_d.range_ok = (period >= nvcd_pkg::PERIOD_W'(nvcd_pkg::MIN_PERIOD_CYC)) &&
                       (period <= nvcd_pkg::PERIOD_W'(nvcd_pkg::MAX_PERIOD_CYC));

        // Prescaler: every cycle, or every eighth one
        if (s_q.ratio.prescale_by_eight) // RULE4
        begin
            pre_tick    = (s_q.pre_cnt == nvcd_pkg::PRE_CNT_W'(nvcd_pkg::PRESCALE_DIV - 1));
            s_d.pre_cnt = s_q.pre_cnt + nvcd_pkg::PRE_CNT_W'(1);
        end
        else
        begin
            pre_tick    = 1'b1;
            s_d.pre_cnt = '0;
        end

        // Divider: one tick every divisor plus one prescaled cycles
        s_d.tick = 1'b0;
        if (pre_tick)
        begin
            if (s_q.div_cnt >= s_q.ratio.divisor) // RULE6
            begin
                s_d.div_cnt = '0;
                s_d.tick    = 1'b1;
            end
            else
            begin
                s_d.div_cnt = s_q.div_cnt + nvcd_pkg::DIVISOR_W'(1);
            end
        end

        // Sticky status flags clear on a one written; a same-cycle set still wins
        if (wr && apb_req.paddr == nvcd_pkg::STATUS_OFFSET)
        begin
            if (apb_req.pwdata[nvcd_pkg::ST_DONE_BIT])
            begin
                s_d.done = 1'b0;
            end
            if (apb_req.pwdata[nvcd_pkg::ST_REFUSED_BIT])
            begin
                s_d.refused = 1'b0;
            end
        end

        // Command write: start an operation or refuse it
        kind  = nvcd_pkg::nvcd_op_type'(apb_req.pwdata[nvcd_pkg::CMD_KIND_LSB +: 2]);
        count = apb_req.pwdata[nvcd_pkg::CMD_COUNT_LSB +: nvcd_pkg::CMD_COUNT_W];
        if (wr && apb_req.paddr == nvcd_pkg::COMMAND_OFFSET)
        begin
            if (s_q.ratio.loaded && s_q.option_valid && s_q.seq == nvcd_pkg::SEQ_IDLE &&
                (kind == nvcd_pkg::OP_PROGRAM || kind == nvcd_pkg::OP_ERASE) && count != '0) // RULE3
            begin
                s_d.seq              = nvcd_pkg::SEQ_ALIGN;
                s_d.remain           = count; // RULE9
                s_d.nv.kind          = kind;
                s_d.nv.target_eeprom = apb_req.pwdata[nvcd_pkg::CMD_TARGET_BIT];
            end
            else
            begin
                s_d.refused = 1'b1; // RULE3
            end
        end

        // Sequencer: pulses begin and end on divided clock boundaries
        s_d.nv.pulse_start = 1'b0;
        unique case (s_q.seq)
            nvcd_pkg::SEQ_IDLE:
            begin
                s_d.nv.active = 1'b0;
            end
            nvcd_pkg::SEQ_ALIGN:
            begin
                if (s_q.tick)
                begin
                    s_d.seq            = nvcd_pkg::SEQ_PULSE;
                    s_d.nv.active      = 1'b1;
                    s_d.nv.pulse_start = 1'b1; // RULE8
                end
            end
            nvcd_pkg::SEQ_PULSE:
            begin
                if (s_q.tick)
                begin
                    if (s_q.remain == nvcd_pkg::CMD_COUNT_W'(1)) // RULE9
                    begin
                        s_d.seq       = nvcd_pkg::SEQ_IDLE;
                        s_d.remain    = '0;
                        s_d.nv.active = 1'b0;
                        s_d.done      = 1'b1;
                    end
                    else
                    begin
                        s_d.remain         = s_q.remain - nvcd_pkg::CMD_COUNT_W'(1);
                        s_d.nv.pulse_start = 1'b1; // RULE8
                    end
                end
            end
            default:
            begin
                s_d.seq       = nvcd_pkg::SEQ_IDLE;
                s_d.nv.active = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    // All state registered here; reset loads constants only
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s_q        <= '0;
            s_q.ratio  <= nvcd_pkg::nvcd_ratio_type'(nvcd_pkg::RATIO_RESET); // RULE2
            s_q.option <= nvcd_pkg::OPTION_RESET;
            s_q.seq    <= nvcd_pkg::SEQ_IDLE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    // Every output taken straight from the state register
    assign apb_rsp           = s_q.rsp;
    assign option_shadow_reg = s_q.option;
    assign ratio_loaded_flag = s_q.ratio.loaded;
    assign nv_timing_clock   = s_q.tick;
    assign nv_ctrl           = s_q.nv;

endmodule

/* tb/nvcd_clock_divider_sva.sv */
// Concurrent checks on the ports of the timing clock divider
module nvcd_clock_divider_sva
(
    input wire logic                       ref_clk,
    input wire logic                       rst,
    input wire nvcd_pkg::nvcd_apb_req_type apb_req,
    input wire nvcd_pkg::nvcd_apb_rsp_type apb_rsp,
    input wire logic [7:0]                 option_nonvolatile_location,
    input wire logic [7:0]                 option_shadow_reg,
    input wire logic                       ratio_loaded_flag,
    input wire logic                       nv_timing_clock,
    input wire nvcd_pkg::nvcd_nv_ctrl_type nv_ctrl
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    logic        ratio_wr;
    logic [11:0] per_q;
    logic [11:0] gap_q;
    logic [1:0]  seen_q;

    // Completed write to the ratio register
    assign ratio_wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
                      && apb_req.paddr == nvcd_pkg::RATIO_OFFSET;

    // Expected tick period, cycles since last tick, ticks seen after capture
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            per_q  <= 12'h000;
            gap_q  <= 12'h000;
            seen_q <= 2'h0;
        end
        else
        begin
            gap_q <= nv_timing_clock ? 12'h001 : gap_q + 12'h001;
            if (ratio_wr && !ratio_loaded_flag)
            begin
                per_q  <= (12'(apb_req.pwdata[5:0]) + 12'h001) * (apb_req.pwdata[6] ? 12'h008 : 12'h001);
                seen_q <= 2'h0;
            end
            else if (nv_timing_clock && ratio_loaded_flag && seen_q != 2'h2)
                seen_q <= seen_q + 2'h1;
        end
    end

    // ------------------------------------------------------------------
    // Sequences and assertions
    // ------------------------------------------------------------------
    sequence s_setup;
        apb_req.psel && !apb_req.penable;
    endsequence

    pready_after_setup_a: assert property (s_setup |=> apb_rsp.pready)
        else $error("pready missing after setup");
    pready_one_cycle_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready held too long");
    loaded_on_write_a: assert property (ratio_wr |=> ratio_loaded_flag)
        else $error("loaded flag not set by ratio write");
    loaded_sticky_a: assert property (ratio_loaded_flag |=> ratio_loaded_flag)
        else $error("loaded flag cleared without reset");
    loaded_cause_a: assert property (!ratio_loaded_flag && !ratio_wr |=> !ratio_loaded_flag)
        else $error("loaded flag set without write");
    no_op_unloaded_a: assert property (!ratio_loaded_flag |-> !nv_ctrl.active)
        else $error("operation active before ratio loaded");
    option_copy_a: assert property ($past(rst) && !rst |=> option_shadow_reg == $past(option_nonvolatile_location))
        else $error("option shadow not copied after reset");
    pulse_after_tick_a: assert property (nv_ctrl.pulse_start |-> $past(nv_timing_clock))
        else $error("timing pulse not aligned to tick");
    pulse_in_op_a: assert property (nv_ctrl.pulse_start |-> nv_ctrl.active)
        else $error("timing pulse outside operation");
    tick_period_a: assert property (nv_timing_clock && seen_q == 2'h2 |-> gap_q == per_q)
        else $error("tick period differs from ratio");
endmodule

/* tb/testbench.sv */
// Self-checking bench for the timing clock divider
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Signals and design
    // ------------------------------------------------------------------
    logic                       ref_clk = 1'b0;
    logic                       rst;
    nvcd_pkg::nvcd_apb_req_type req;
    nvcd_pkg::nvcd_apb_rsp_type rsp;
    logic [7:0]                 opt_loc;
    logic [7:0]                 opt_shadow;
    logic                       loaded;
    logic                       tick;
    nvcd_pkg::nvcd_nv_ctrl_type ctrl;
    logic [31:0]                rd;
    logic                       err;
    int                         gap;
    int                         errors = 0;
    int                         n_checks = 0;

    nvcd_clock_divider nvcd_clock_divider_inst
    (
        .ref_clk                     (ref_clk),
        .rst                         (rst),
        .apb_req                     (req),
        .apb_rsp                     (rsp),
        .option_nonvolatile_location (opt_loc),
        .option_shadow_reg           (opt_shadow),
        .ratio_loaded_flag           (loaded),
        .nv_timing_clock             (tick),
        .nv_ctrl                     (ctrl)
    );

    // 50 MHz clock
    always #10 ref_clk = ~ref_clk;

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    // Report and end the run
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Compare seen against expected
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer, waiting for pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (rsp.pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            errors++;
            wrap_up();
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    // Cycles between two ticks, measured on the third tick
    task automatic tick_gap;
        repeat (3)
        begin
            gap = 0;
            do
            begin
                @(posedge ref_clk);
                gap++;
            end
            while (tick !== 1'b1 && gap < 2000);
        end
        if (gap >= 2000)
        begin
            errors++;
            wrap_up();
        end
    endtask

    // Run one operation and measure its length and pulses
    task automatic run_op(input logic [1:0] kind, input logic tgt, input logic [7:0] cnt, input int per);
        int act;
        int pul;
        int n;
        act = 0;
        pul = 0;
        n = 0;
        apb(1'b1, nvcd_pkg::COMMAND_OFFSET, {16'h0000, cnt, 5'h00, tgt, kind});
        while (n < 4000 && !(act > 0 && ctrl.active !== 1'b1))
        begin
            @(posedge ref_clk);
            n++;
            if (ctrl.active === 1'b1)
                act++;
            if (ctrl.pulse_start === 1'b1)
                pul++;
        end
        check("active cycles", act, int'(cnt) * per);
        check("pulse count", pul, 32'(cnt));
        check("op kind", {29'h0, ctrl.target_eeprom, ctrl.kind}, {29'h0, tgt, kind});
        apb(1'b0, nvcd_pkg::STATUS_OFFSET, 32'h0000_0000);
        check("status done", rd & 32'h0000_FF07, 32'h0000_0002);
        apb(1'b1, nvcd_pkg::STATUS_OFFSET, 32'h0000_0006);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        req = '0;
        opt_loc = 8'hA5;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b0, nvcd_pkg::OPTION_OFFSET, 32'h0000_0000);
        check("option", rd, 32'h0000_00A5);
        apb(1'b0, nvcd_pkg::RATIO_OFFSET, 32'h0000_0000);
        check("ratio reset", rd, 32'h0000_0000);
        apb(1'b1, nvcd_pkg::COMMAND_OFFSET, 32'h0000_0101);
        apb(1'b0, nvcd_pkg::STATUS_OFFSET, 32'h0000_0000);
        check("refused unloaded", rd & 32'h0000_0005, 32'h0000_0004);
        apb(1'b1, nvcd_pkg::STATUS_OFFSET, 32'h0000_0004);
        apb(1'b1, nvcd_pkg::RATIO_OFFSET, 32'h0000_005F);
        apb(1'b0, nvcd_pkg::RATIO_OFFSET, 32'h0000_0000);
        check("ratio first", rd, 32'h0000_00DF);
        apb(1'b1, nvcd_pkg::RATIO_OFFSET, 32'h0000_0000);
        apb(1'b0, nvcd_pkg::RATIO_OFFSET, 32'h0000_0000);
        check("ratio second", rd, 32'h0000_00DF);
        tick_gap();
        check("prescaled period", gap, 256);
        apb(1'b0, nvcd_pkg::STATUS_OFFSET, 32'h0000_0000);
        check("in range", rd & 32'h0000_000F, 32'h0000_0008);
        apb(1'b0, 12'h010, 32'h0000_0000);
        check("unmapped", {err, rd[30:0]}, 32'h8000_0000);
        // Second reset in mid-run with a new option value
        rst <= 1'b1;
        opt_loc <= 8'h3C;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b0, nvcd_pkg::OPTION_OFFSET, 32'h0000_0000);
        check("option new", rd, 32'h0000_003C);
        check("shadow pin", opt_shadow, 32'h0000_003C);
        check("loaded cleared", loaded, 1'b0);
        apb(1'b1, nvcd_pkg::RATIO_OFFSET, 32'h0000_0004);
        tick_gap();
        check("plain period", gap, 5);
        run_op(nvcd_pkg::OP_ERASE, 1'b1, 8'h03, 5);
        run_op(nvcd_pkg::OP_PROGRAM, 1'b0, 8'h01, 5);
        apb(1'b1, nvcd_pkg::COMMAND_OFFSET, 32'h0000_0103);
        apb(1'b0, nvcd_pkg::STATUS_OFFSET, 32'h0000_0000);
        check("illegal kind", rd & 32'h0000_0005, 32'h0000_0004);
        // Zero pulse count is refused as well
        apb(1'b1, nvcd_pkg::STATUS_OFFSET, 32'h0000_0004);
        apb(1'b1, nvcd_pkg::COMMAND_OFFSET, 32'h0000_0002);
        apb(1'b0, nvcd_pkg::STATUS_OFFSET, 32'h0000_0000);
        check("zero count", rd & 32'h0000_0005, 32'h0000_0004);
        // A second command while one is running is refused
        apb(1'b1, nvcd_pkg::STATUS_OFFSET, 32'h0000_0004);
        apb(1'b1, nvcd_pkg::COMMAND_OFFSET, 32'h0000_0102);
        apb(1'b1, nvcd_pkg::COMMAND_OFFSET, 32'h0000_0102);
        apb(1'b0, nvcd_pkg::STATUS_OFFSET, 32'h0000_0000);
        check("busy refused", rd & 32'h0000_0005, 32'h0000_0005);
        wrap_up();
    end
endmodule

bind nvcd_clock_divider nvcd_clock_divider_sva nvcd_clock_divider_sva_inst
(
    .ref_clk                     (ref_clk),
    .rst                         (rst),
    .apb_req                     (apb_req),
    .apb_rsp                     (apb_rsp),
    .option_nonvolatile_location (option_nonvolatile_location),
    .option_shadow_reg           (option_shadow_reg),
    .ratio_loaded_flag           (ratio_loaded_flag),
    .nv_timing_clock             (nv_timing_clock),
    .nv_ctrl                     (nv_ctrl)
);
